// [vrp_pkg.sv]
// Purpose: Constants for the voice recorder phrase controller
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes:   Analog routing is shown as select codes, not analog levels
//
// What this block does
// - Reset stops work, powers down, reinitialises all but the block owner table
// - Reset mid-operation leaves voice data undefined
// - Power-down drives all four chip selects high
// - Power-down sets fixed pin levels, filters grounded
// - Sleep pin halts activity, keeps state intact
// - Sleep during record/play stops, postprocesses after
// - Sleep during deletion suspends, continues after release
// - Sleep during speaker settle suspends, then continues
// - Fixed-message select picks DRAM or voice ROM
// - DRAM split into 256 equal blocks
// - Record only into own or unused blocks
// - Deleting phrase frees all its blocks
// - Size selects give 8/16/24/32M capacity
// - Initial free blocks 254, 255, 191, 255
// - ROM playback fetches phrase index data first
// - Code zero erase clears all 63 phrases
// - Codes 1..63 erase only that phrase
// - Filter and speaker outputs routed by state
// - Analog monitor follows amp or DA converter
// - Filter cut-off tracks 0.4 times sampling rate
// - Standby select chooses standby or auto power-down
// - Activity monitor high during record or playback
// - Record/playback select: low play, high record
package vrp_pkg;
    localparam int          NUM_BLOCKS      = 256;
    localparam int          NUM_PHRASES     = 63;
    localparam logic [5:0]  PHRASE_ALL      = 6'h00;
    localparam logic [5:0]  OWNER_FREE      = 6'h00;
    localparam logic [7:0]  RESERVED_8M     = 8'h01;
    localparam logic [7:0]  FIRST_24M_HOLE  = 8'hC0;
    localparam int          INDEX_WORDS     = 4;
    localparam int          SETTLE_CYCLES   = 64;
    localparam int          POST_CYCLES     = 16;
    localparam int          CUTOFF_NUM      = 2;
    localparam int          CUTOFF_DEN      = 5;
    // Analog route codes
    localparam logic [1:0]  ROUTE_GND       = 2'h0;
    localparam logic [1:0]  ROUTE_SG        = 2'h1;
    localparam logic [1:0]  ROUTE_FILTER    = 2'h2;
    localparam logic [1:0]  ROUTE_AMP       = 2'h0;
    localparam logic [1:0]  ROUTE_DAC       = 2'h1;
    typedef enum logic [2:0] {
        VRP_IDLE, VRP_ERASE, VRP_RECORD, VRP_PLAY, VRP_FETCH, VRP_POST, VRP_SETTLE, VRP_DOWN
    } vrp_state_type;
endpackage : vrp_pkg

// [vrp_buf2.sv]
// Purpose: Two-entry valid/ready buffer on the voice data path
// Assumes: Single clock, synchronous reset
// Notes:   Full throughput; a stalled drain side loses no word
module vrp_buf2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem [2];
    logic             rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
    logic [1:0]       count, next_count;
    logic             push, pop;

    always_comb begin
        push        = in_valid && (count != 2'h2);
        pop         = out_ready && (count != 2'h0);
        next_wr_ptr = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
        next_count  = count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
endmodule : vrp_buf2

// [vrp_ctrl.sv]
// Purpose: Phrase, block and power control of the voice recorder
// Assumes: Host pins synchronous to clk; oscillator halt is a clock-gating request
// Notes:   While recording, one block is claimed per block_done pulse that lands on a usable, unreserved block
module vrp_ctrl
    import vrp_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              sleep_request_n,
    input  wire logic              idle_standby_select,
    input  wire logic              fixed_message_select,
    input  wire logic              record_playback_select,
    input  wire logic              start_n,
    input  wire logic              stop_n,
    input  wire logic              phrase_erase_n,
    input  wire logic [5:0]        phrase_code,
    input  wire logic              mem_size_sel_lo,
    input  wire logic              mem_size_sel_hi,
    input  wire logic              block_done,
    input  wire logic              rom_word_valid,
    input  wire logic [DATA_W-1:0] voice_in_data,
    input  wire logic              voice_in_valid,
    output logic                   voice_in_ready,
    output logic      [DATA_W-1:0] voice_out_data,
    output logic                   voice_out_valid,
    input  wire logic              voice_out_ready,
    output logic      [3:0]        memory_chip_select_n,
    output logic                   serial_addr_data_x,
    output logic                   serial_addr_data_y,
    output logic                   serial_addr_strobe,
    output logic                   transfer_addr_strobe,
    output logic                   write_enable_n,
    output logic                   memory_rw_clock,
    output logic                   phrase_accept_flag,
    output logic                   activity_monitor,
    output logic                   oscillator_run,
    output logic      [1:0]        speaker_route,
    output logic      [1:0]        filter_monitor_route,
    output logic      [1:0]        analog_monitor_route,
    output logic      [7:0]        current_block,
    output logic      [8:0]        free_blocks,
    output logic      [7:0]        cutoff_ratio_tenths
);
    ////////////////////////////////////////////////////////////////////////////
    // Block ownership and state
    logic [5:0]    owner [NUM_BLOCKS];
    vrp_state_type state, next_state, resume_state, next_resume_state;
    logic [7:0]    scan, next_scan;
    logic [7:0]    blk, next_blk;
    logic [5:0]    phrase, next_phrase;
    logic [6:0]    timer, next_timer;
    logic          erase_all, next_erase_all;
    logic [8:0]    free_cnt, next_free_cnt;
    logic          claim;
    logic          buf_valid, buf_ready;
    logic [DATA_W-1:0] buf_data;

    function automatic logic usable(input logic [5:0] own, input logic [5:0] ph);
        usable = (own == OWNER_FREE) || (own == ph);
    endfunction : usable

    // Blocks hidden per size: index area, the 8M reserved block and missing 24M quarter
    function automatic logic reserved_blk(input logic [7:0] b, input logic lo, input logic hi);
        reserved_blk = (b == 8'h00) || (!lo && !hi && b == RESERVED_8M) || (!lo && hi && b >= FIRST_24M_HOLE);
    endfunction : reserved_blk

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state        = state;
        next_resume_state = resume_state;
        next_scan         = scan;
        next_blk          = blk;
        next_phrase       = phrase;
        next_timer        = timer;
        next_erase_all    = erase_all;
        next_free_cnt     = free_cnt;
        claim             = 1'b0;
        if (state != VRP_DOWN && !sleep_request_n) begin
            // Record/playback abort into postprocess; others resume in place
            next_resume_state = (state == VRP_RECORD || state == VRP_PLAY || state == VRP_FETCH) ? VRP_POST : state;
            next_state        = VRP_DOWN;
            if (state == VRP_RECORD || state == VRP_PLAY || state == VRP_FETCH) begin
                next_timer = 7'(POST_CYCLES);
            end
        end else begin
            case (state)
                VRP_DOWN: begin
                    if (sleep_request_n) begin
                        next_state = resume_state;
                    end
                end
                VRP_IDLE: begin
                    if (!phrase_erase_n) begin
                        next_erase_all = (phrase_code == PHRASE_ALL);
                        next_phrase    = phrase_code;
                        next_scan      = 8'h00;
                        next_state     = VRP_ERASE;
                    end else if (!start_n && phrase_code != PHRASE_ALL) begin
                        next_phrase = phrase_code;
                        next_scan   = 8'h00;
                        next_timer  = 7'(INDEX_WORDS);
                        if (fixed_message_select) begin
                            next_state = VRP_FETCH;
                        end else if (record_playback_select) begin
                            next_state = VRP_RECORD;
                        end else begin
                            next_state = VRP_PLAY;
                        end
                    end
                end
                VRP_ERASE: begin
                    next_scan = scan + 8'h01;
                    if (scan == 8'hFF) begin
                        next_timer = 7'(SETTLE_CYCLES);
                        next_state = VRP_SETTLE;
                    end
                end
                VRP_FETCH: begin
                    if (rom_word_valid) begin
                        next_timer = timer - 7'h01;
                        if (timer == 7'h01) begin
                            next_state = VRP_PLAY;
                        end
                    end
                end
                VRP_RECORD: begin
                    if (!stop_n) begin
                        next_timer = 7'(POST_CYCLES);
                        next_state = VRP_POST;
                    end else if (!usable(owner[scan], phrase) || reserved_blk(scan, mem_size_sel_lo, mem_size_sel_hi)) begin
                        next_scan = scan + 8'h01;
                        if (scan == 8'hFF) begin
                            next_timer = 7'(POST_CYCLES);
                            next_state = VRP_POST;
                        end
                    end else if (block_done) begin
                        next_blk  = scan;
                        next_scan = scan + 8'h01;
                        claim     = 1'b1;
                        if (owner[scan] == OWNER_FREE) begin
                            next_free_cnt = free_cnt - 9'h001;
                        end
                        if (scan == 8'hFF) begin
                            next_timer = 7'(POST_CYCLES);
                            next_state = VRP_POST;
                        end
                    end
                end
                VRP_PLAY: begin
                    if (!stop_n || block_done && scan == 8'hFF) begin
                        next_timer = 7'(POST_CYCLES);
                        next_state = VRP_POST;
                    end else if (block_done) begin
                        next_blk  = scan;
                        next_scan = scan + 8'h01;
                    end
                end
                VRP_POST, VRP_SETTLE: begin
                    next_timer = timer - 7'h01;
                    if (timer == 7'h01) begin
                        next_state = (state == VRP_POST) ? VRP_SETTLE : VRP_IDLE;
                        next_timer = 7'(SETTLE_CYCLES);
                    end
                end
                default: next_state = VRP_IDLE;
            endcase
            // Free count recount during erasure sweep
            if (state == VRP_ERASE) begin
                if (erase_all) begin
                    next_free_cnt = (scan == 8'h00) ? 9'h000 : free_cnt;
                    if (!reserved_blk(scan, mem_size_sel_lo, mem_size_sel_hi)) begin
                        next_free_cnt = next_free_cnt + 9'h001;
                    end
                end else if (owner[scan] == phrase && phrase != OWNER_FREE) begin
                    next_free_cnt = free_cnt + 9'h001;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state        <= VRP_IDLE;
            resume_state <= VRP_IDLE;
            scan         <= 8'h00;
            blk          <= 8'h00;
            phrase       <= 6'h00;
            timer        <= 7'h00;
            erase_all    <= 1'b0;
            free_cnt     <= 9'h000;
        end else begin
            state        <= next_state;
            resume_state <= next_resume_state;
            scan         <= next_scan;
            blk          <= next_blk;
            phrase       <= next_phrase;
            timer        <= next_timer;
            erase_all    <= next_erase_all;
            free_cnt     <= next_free_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Owner table, one entry per block
    generate
        for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_owner
            always_ff @(posedge clk) begin
                if (state == VRP_ERASE && scan == 8'(g) && (erase_all || owner[g] == phrase)) begin
                    owner[g] <= OWNER_FREE;
                end else if (claim && scan == 8'(g)) begin
                    owner[g] <= phrase;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Voice buffer fills only while recording or playing
    vrp_buf2 #(
        .WIDTH (DATA_W)
    ) u_buf (
        .clk       (clk),
        .reset     (reset),
        .in_data   (voice_in_data),
        .in_valid  (voice_in_valid && (state == VRP_RECORD || state == VRP_PLAY)),
        .in_ready  (buf_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (voice_out_ready || !voice_out_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered pins
    logic low_power, active, rec_mode;
    always_comb begin
        low_power = reset || state == VRP_DOWN || (state == VRP_IDLE && !idle_standby_select);
        active    = (state == VRP_RECORD || state == VRP_PLAY);
        rec_mode  = (state == VRP_RECORD);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            memory_chip_select_n <= 4'hF;
            serial_addr_data_x   <= 1'b1;
            serial_addr_data_y   <= 1'b0;
            serial_addr_strobe   <= 1'b1;
            transfer_addr_strobe <= 1'b1;
            write_enable_n       <= 1'b1;
            memory_rw_clock      <= 1'b1;
            phrase_accept_flag   <= 1'b1;
            activity_monitor     <= 1'b0;
            oscillator_run       <= 1'b0;
            speaker_route        <= ROUTE_GND;
            filter_monitor_route <= ROUTE_GND;
            analog_monitor_route <= ROUTE_AMP;
            voice_in_ready       <= 1'b0;
            voice_out_data       <= '0;
            voice_out_valid      <= 1'b0;
            current_block        <= 8'h00;
            free_blocks          <= 9'h000;
            cutoff_ratio_tenths  <= 8'h00;
        end else begin
            oscillator_run       <= !low_power;
            activity_monitor     <= active;
            voice_in_ready       <= buf_ready && active;
            if (voice_out_ready || !voice_out_valid) begin
                voice_out_valid <= buf_valid;
                voice_out_data  <= buf_data;
            end
            current_block        <= blk;
            free_blocks          <= free_cnt;
            cutoff_ratio_tenths  <= 8'(10 * CUTOFF_NUM / CUTOFF_DEN);
            if (low_power) begin
                memory_chip_select_n <= 4'hF;
                serial_addr_data_x   <= 1'b1;
                serial_addr_data_y   <= 1'b0;
                serial_addr_strobe   <= 1'b1;
                transfer_addr_strobe <= 1'b1;
                write_enable_n       <= 1'b1;
                memory_rw_clock      <= 1'b1;
                phrase_accept_flag   <= 1'b1;
                speaker_route        <= ROUTE_GND;
                filter_monitor_route <= ROUTE_GND;
            end else begin
                // ROM chips on upper selects, DRAM interface on the lower
                memory_chip_select_n <= (active || state == VRP_FETCH || state == VRP_ERASE)
                                        ? (fixed_message_select ? 4'h3 : 4'hC) : 4'hF;
                serial_addr_data_x   <= blk[0];
                serial_addr_data_y   <= blk[1];
                serial_addr_strobe   <= !(state == VRP_FETCH);
                transfer_addr_strobe <= !(block_done && active);
                write_enable_n       <= !rec_mode;
                memory_rw_clock      <= !(active && voice_in_valid);
                phrase_accept_flag   <= (state == VRP_IDLE);
                filter_monitor_route <= ROUTE_FILTER;
                speaker_route        <= rec_mode ? (idle_standby_select ? ROUTE_SG : ROUTE_GND)
                                        : ROUTE_FILTER;
                analog_monitor_route <= rec_mode ? ROUTE_AMP : ROUTE_DAC;
            end
        end
    end
endmodule : vrp_ctrl

// [vrp_ctrl_sva.sv]
// Purpose: Port-level checks of the phrase controller
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only ports; bound to vrp_ctrl below
module vrp_ctrl_sva
    import vrp_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              sleep_request_n,
    input wire logic              fixed_message_select,
    input wire logic              start_n,
    input wire logic              phrase_erase_n,
    input wire logic [5:0]        phrase_code,
    input wire logic [DATA_W-1:0] voice_out_data,
    input wire logic              voice_out_valid,
    input wire logic              voice_out_ready,
    input wire logic [3:0]        memory_chip_select_n,
    input wire logic              serial_addr_data_x,
    input wire logic              serial_addr_data_y,
    input wire logic              serial_addr_strobe,
    input wire logic              transfer_addr_strobe,
    input wire logic              write_enable_n,
    input wire logic              memory_rw_clock,
    input wire logic              phrase_accept_flag,
    input wire logic              activity_monitor,
    input wire logic              oscillator_run,
    input wire logic [1:0]        speaker_route,
    input wire logic [1:0]        filter_monitor_route,
    input wire logic [7:0]        current_block,
    input wire logic [8:0]        free_blocks,
    input wire logic [7:0]        cutoff_ratio_tenths
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    // Halt has landed by the third cycle
    sequence s_asleep;
        !sleep_request_n [*3];
    endsequence
    sequence s_taken;
        !start_n && sleep_request_n && phrase_erase_n && phrase_code != 6'h00
            && !fixed_message_select && !activity_monitor;
    endsequence
    a_reset_pins:
    assert property ($past(reset) |-> memory_chip_select_n == 4'hF && serial_addr_data_x && serial_addr_strobe
        && transfer_addr_strobe && write_enable_n && memory_rw_clock && phrase_accept_flag && !serial_addr_data_y
        && !activity_monitor && !oscillator_run && speaker_route == ROUTE_GND && filter_monitor_route == ROUTE_GND)
        else $error("pins wrong after reset");
    a_down_pins:
    assert property (!oscillator_run |-> memory_chip_select_n == 4'hF && !activity_monitor
        && speaker_route == ROUTE_GND && filter_monitor_route == ROUTE_GND) else $error("pins wrong when down");
    a_sleep_hold:
    assert property (s_asleep |-> $stable(current_block) && $stable(free_blocks) && memory_chip_select_n == 4'hF)
        else $error("state moved in sleep");
    a_start_answer:
    assert property (s_taken |-> ##[1:8] activity_monitor) else $error("start not answered");
    a_active_route:
    assert property (activity_monitor |-> filter_monitor_route == ROUTE_FILTER && oscillator_run)
        else $error("route wrong while active");
    a_active_cs:
    assert property (activity_monitor |-> memory_chip_select_n == (fixed_message_select ? 4'h3 : 4'hC))
        else $error("chip select wrong");
    a_cutoff_ratio:
    assert property (oscillator_run |-> cutoff_ratio_tenths == 8'h04) else $error("cutoff ratio wrong");
    a_free_range:
    assert property (free_blocks <= 9'h0FF) else $error("free count too big");
    a_claim_step:
    assert property (activity_monitor |-> $past(free_blocks) <= free_blocks + 9'h001)
        else $error("free count fell too fast");
    a_out_hold:
    assert property (voice_out_valid && !voice_out_ready |=> voice_out_valid && $stable(voice_out_data))
        else $error("stalled word dropped");
endmodule : vrp_ctrl_sva

bind vrp_ctrl vrp_ctrl_sva #(.DATA_W(DATA_W)) u_vrp_ctrl_sva (.*);

// [vrp_mem_model.sv]
// Purpose: Far-side memory and voice stream model
// Assumes: GAP sets block pace; stall holds the drain side
// Notes:   Deselected data lines change every cycle unless an offered word still waits
module vrp_mem_model
    import vrp_pkg::*;
#(
    parameter int GAP = 20
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [3:0] memory_chip_select_n,
    input  wire logic       activity_monitor,
    input  wire logic       stall,
    output logic            block_done,
    output logic            rom_word_valid,
    output logic      [7:0] voice_in_data,
    output logic            voice_in_valid,
    input  wire logic       voice_in_ready,
    output logic            voice_out_ready
);
    int cnt;
    ////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= 0;
            block_done <= 1'b0;
            rom_word_valid <= 1'b0;
            voice_in_valid <= 1'b0;
            voice_in_data <= 8'h00;
            voice_out_ready <= 1'b0;
        end else begin
            cnt <= (cnt == GAP - 1 || !activity_monitor) ? 0 : cnt + 1;
            block_done <= cnt == GAP - 1 && activity_monitor && memory_chip_select_n != 4'hF;
            rom_word_valid <= cnt[1:0] == 2'h0 && memory_chip_select_n == 4'h3;
            // A word once offered stays until taken
            if (!voice_in_valid || voice_in_ready) begin
                voice_in_valid <= memory_chip_select_n != 4'hF;
                voice_in_data <= voice_in_valid ? voice_in_data + 8'h01 : ~voice_in_data;
            end
            voice_out_ready <= !stall;
        end
    end
endmodule : vrp_mem_model

// [vrp_ctrl_tb_top.sv]
// Purpose: Self-checking bench of the phrase controller
// Assumes: Inputs move on the falling edge
// Notes:   Erase waits are fixed at 400 cycles, above sweep 256 plus settle 64
module vrp_ctrl_tb_top;
    import vrp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, reset, sleep_n, standby, fixed, rps, start_n, stop_n, erase_n, sel_lo, sel_hi, stall;
    logic       block_done, rom_valid, in_valid, in_ready, out_valid, out_ready, act, osc;
    logic [5:0] code;
    logic [7:0] in_data, out_data, current_block, held;
    logic [3:0] cs_n;
    logic [1:0] spk, fmon, analog_monitor_out;
    logic [8:0] free_blocks;
    logic [8:0] init_free [4] = '{9'h0FE, 9'h0FF, 9'h0BF, 9'h0FF};
    int         error_cnt, compares, nblk, n1;
    ////////////////////////////////////////
    vrp_ctrl u_vrp_ctrl (.clk, .reset, .sleep_request_n(sleep_n), .idle_standby_select(standby),
        .fixed_message_select(fixed), .record_playback_select(rps), .start_n, .stop_n,
        .phrase_erase_n(erase_n), .phrase_code(code), .mem_size_sel_lo(sel_lo), .mem_size_sel_hi(sel_hi),
        .block_done, .rom_word_valid(rom_valid), .voice_in_data(in_data),
        .voice_in_valid(in_valid), .voice_in_ready(in_ready), .voice_out_data(out_data),
        .voice_out_valid(out_valid), .voice_out_ready(out_ready), .memory_chip_select_n(cs_n),
        .serial_addr_data_x(), .serial_addr_data_y(), .serial_addr_strobe(), .transfer_addr_strobe(),
        .write_enable_n(), .memory_rw_clock(), .phrase_accept_flag(), .activity_monitor(act),
        .oscillator_run(osc), .speaker_route(spk), .filter_monitor_route(fmon), .analog_monitor_route(analog_monitor_out),
        .current_block, .free_blocks, .cutoff_ratio_tenths());
    vrp_mem_model u_vrp_mem_model (.clk, .reset, .memory_chip_select_n(cs_n),
        .activity_monitor(act), .stall, .block_done, .rom_word_valid(rom_valid),
        .voice_in_data(in_data), .voice_in_valid(in_valid), .voice_in_ready(in_ready),
        .voice_out_ready(out_ready));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Counted only while recording to DRAM
    always @(posedge clk) if ((act & block_done) === 1'b1 && rps && !fixed) nblk++;
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task summarize;
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task erase(input logic [5:0] c);
        code = c;
        erase_n = 1'b0;
        cyc(1);
        erase_n = 1'b1;
    endtask : erase
    task start(input logic [5:0] c);
        code = c;
        start_n = 1'b0;
        cyc(1);
        start_n = 1'b1;
    endtask : start
    task fail;
        error_cnt++;
        summarize();
    endtask : fail
    task wait_act(input logic v);
        for (int i = 0; i < 200 && act !== v; i++) cyc(1);
        if (act !== v) fail();
    endtask : wait_act
    // Act just after a block pulse to avoid count races
    task sync_blk;
        for (int i = 0; i < 100 && block_done !== 1'b1; i++) cyc(1);
        if (block_done !== 1'b1) fail();
        cyc(3);
    endtask : sync_blk
    task stop_op;
        sync_blk();
        stop_n = 1'b0;
        cyc(1);
        stop_n = 1'b1;
        wait_act(1'b0);
        cyc(100);
    endtask : stop_op
    initial begin
        {reset, sleep_n, standby, rps, start_n, stop_n, erase_n, sel_lo, sel_hi} = 9'h1FF;
        {fixed, stall, code, nblk} = '0;
        cyc(10);
        reset = 1'b0;
        chk(cs_n, 4'hF);
        chk(free_blocks, 9'h000);
        for (int k = 0; k < 4; k++) begin
            {sel_hi, sel_lo} = 2'(k);
            erase(6'h00);
            cyc(400);
            chk(free_blocks, init_free[k]);
        end
        erase(6'h00);
        cyc(50);
        sleep_n = 1'b0;
        cyc(100);
        chk({osc, cs_n}, 5'h0F);
        sleep_n = 1'b1;
        cyc(400);
        chk(free_blocks, 9'h0FF);
        nblk = 0;
        start(6'h01);
        wait_act(1'b1);
        chk(analog_monitor_out, ROUTE_AMP);
        chk(spk, ROUTE_SG);
        stall = 1'b1;
        cyc(100);
        stall = 1'b0;
        sync_blk();
        sleep_n = 1'b0;
        cyc(5);
        held = current_block;
        cyc(60);
        chk(current_block, held);
        chk(act, 1'b0);
        sleep_n = 1'b1;
        cyc(200);
        chk(act, 1'b0);
        chk(free_blocks, 9'(255 - nblk));
        n1 = nblk;
        nblk = 0;
        start(6'h02);
        wait_act(1'b1);
        cyc(80);
        stop_op();
        chk(free_blocks, 9'(255 - n1 - nblk));
        erase(6'h01);
        cyc(400);
        chk(free_blocks, 9'(255 - nblk));
        rps = 1'b0;
        start(6'h02);
        wait_act(1'b1);
        chk({analog_monitor_out, spk, cs_n}, {ROUTE_DAC, ROUTE_FILTER, 4'hC});
        stop_op();
        start(6'h00);
        cyc(20);
        chk(act, 1'b0);
        fixed = 1'b1;
        start(6'h03);
        wait_act(1'b1);
        chk(cs_n, 4'h3);
        stop_op();
        fixed = 1'b0;
        standby = 1'b0;
        cyc(100);
        chk({osc, cs_n}, 5'h0F);
        rps = 1'b1;
        start(6'h05);
        wait_act(1'b1);
        chk({spk, fmon}, {ROUTE_GND, ROUTE_FILTER});
        cyc(20);
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        cyc(1);
        chk({act, cs_n}, 5'h0F);
        chk(free_blocks, 9'h000);
        summarize();
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail();
    end
endmodule : vrp_ctrl_tb_top
